// file: src/bfs_supervisor.sv
// Top of the buck fault supervisor: protection, power ok, ramp mode, registers.
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "bfs_cfg.svh"
module bfs_supervisor #(
	parameter int unsigned FILT_CYC = `BFS_FILT_CYC,
	parameter int unsigned HOLD_CYC = `BFS_HOLD_CYC
) (
	// Clock and reset.
	input  wire logic        I_MCLK,
	input  wire logic        I_RST_N,
	// Bias supply above its start level.
	input  wire logic        I_POR_OK,
	// Channel enables, bit 0 is channel 1.
	input  wire logic [1:0]  I_CHANNEL_ENABLE,
	// PWM timing per channel.
	input  wire logic [1:0]  I_PWM_TICK,
	input  wire logic [1:0]  I_PWM_DEMAND,
	// Analog comparator decisions per channel.
	input  wire logic [1:0]  I_CURRENT_SENSE_OVER,
	input  wire logic [1:0]  I_FEEDBACK_SENSE_UNDER,
	input  wire logic [1:0]  I_FEEDBACK_SENSE_IN_WIN,
	input  wire logic [1:0]  I_SOFT_QUAL,
	// Gate waveform monitors.
	input  wire logic [1:0]  I_HIGH_SIDE_GATE_MON,
	input  wire logic [1:0]  I_LOW_SIDE_GATE_MON,
	// Ramp supply sense decisions.
	input  wire logic        I_RAMP_SUPPLY_SENSE_GND,
	input  wire logic        I_RAMP_SUPPLY_SENSE_HIGH,
	// Register port.
	input  wire logic [7:0]  I_ADDR,
	input  wire logic [31:0] I_WDATA,
	input  wire logic        I_WR,
	input  wire logic        I_RD,
	output logic      [31:0] O_RDATA,
	// Gate drives.
	output logic      [1:0]  O_HIGH_SIDE_GATE,
	output logic      [1:0]  O_LOW_SIDE_GATE,
	// Open-drain power ok, per channel.
	output logic      [1:0]  O_POWER_OK_OUTPUT,
	output logic      [1:0]  O_POWER_OK_OUTPUT_OE_N,
	// Soft-start running, per channel.
	output logic      [1:0]  O_SOFT_START_RUN,
	// Ramp generator selection.
	output logic             O_RAMP_FROM_BIAS,
	output logic             O_RAMP_AMPLITUDE_DIV8
);
	// ************************************************************
	// Shared signals
	// ************************************************************
	logic                latch_clr;
	logic [1:0]          win_filt;
	logic [1:0]          want_hs;
	logic [1:0]          ch_pok;
	logic [1:0]          ch_foc;
	logic [1:0]          ch_fuv;
	logic [1:0]          ch_soft;
	logic [1:0]          ch_run;
	logic [1:0]          ch_ocact;
	logic [1:0]          smp;
	logic [1:0]          hs_drv;
	logic [1:0]          ls_drv;
	logic [31:0]         stat_word;
	bfs_pkg::bfs_top_s   t_reg;
	bfs_pkg::bfs_top_s   t_next;

	// Address match, used by the write and the read path.
	function automatic logic bfs_hit(input logic [7:0] a, input logic [7:0] off);
		bfs_hit = (a == off);
	endfunction

	// Latches clear with both enables low or when the bias supply is lost.
	assign latch_clr = (~I_CHANNEL_ENABLE[0] & ~I_CHANNEL_ENABLE[1]) | ~I_POR_OK;

	// ************************************************************
	// Per-channel protection
	// ************************************************************
	generate
		for (genvar g = 0; g < 2; g++) begin : g_ch
			bfs_pkg::bfs_ch_s   c_reg;
			bfs_pkg::bfs_ch_s   c_next;
			bfs_pkg::bfs_gate_s gate;
			logic               uv_set;
			logic               oc_set;
			logic               ch_alive;

			// Window decision is filtered before it may touch power ok.
			bfs_filter #(
				.CNT (FILT_CYC)
			) u_win (
				.i_clk   (I_MCLK),
				.i_rst_n (I_RST_N),
				.i_raw   (I_FEEDBACK_SENSE_IN_WIN[g]),
				.o_filt  (win_filt[g])
			);

			// Held overcurrent blocks the high-side demand.
			assign want_hs[g] = I_PWM_DEMAND[g] & ~c_reg.oc_held;

			bfs_gate_seq #(
				.HOLD (HOLD_CYC)
			) u_gate (
				.i_clk     (I_MCLK),
				.i_rst_n   (I_RST_N),
				.i_allow   (c_reg.run),
				.i_want_hs (want_hs[g]),
				.i_hs_fb   (I_HIGH_SIDE_GATE_MON[g]),
				.i_ls_fb   (I_LOW_SIDE_GATE_MON[g]),
				.o_gate    (gate)
			);

			assign smp[g]    = gate.sample;
			assign hs_drv[g] = gate.hs;
			assign ls_drv[g] = gate.ls;

			// Undervoltage only counts once soft-start has qualified.
			assign uv_set = c_reg.run & c_reg.soft_done & I_FEEDBACK_SENSE_UNDER[g]
				& t_reg.cfg[`BFS_CFG_UV_LSB + g];
			// A trip seen in the second interval ends in a latched shutdown.
			assign oc_set = (c_reg.oc_st == bfs_pkg::BFS_OC_WATCH) & c_reg.oc_held;
			assign ch_alive = I_POR_OK & I_CHANNEL_ENABLE[g];

			// Next state of the channel.
			always_comb begin
				c_next = c_reg;
				// Soft-start runs with bias good, enable high and no latch.
				c_next.run = ch_alive & ~c_reg.fault_oc & ~c_reg.fault_uv;
				// Qualification is sticky until the channel is disabled or the bias supply is lost.
				if (!ch_alive) begin
					c_next.soft_done = 1'b0;
				end else if (c_reg.run && I_SOFT_QUAL[g]) begin
					c_next.soft_done = 1'b1;
				end
				// Current is held at the sample strobe; while over the level it is
				// followed every cycle the low side conducts, so the next pulse is
				// released as soon as the current falls back.
				if (!c_reg.run) begin
					c_next.oc_held = 1'b0;
				end else if (smp[g] || (c_reg.oc_held && ls_drv[g])) begin
					c_next.oc_held = I_CURRENT_SENSE_OVER[g];
				end
				// Overcurrent sequencer counted in switching cycles.
				case (c_reg.oc_st)
					bfs_pkg::BFS_OC_IDLE: begin
						c_next.tick_cnt = 5'h00;
						if (c_reg.run && c_reg.oc_held) begin
							c_next.oc_st = bfs_pkg::BFS_OC_SKIP;
						end
					end
					bfs_pkg::BFS_OC_SKIP: begin
						if (I_PWM_TICK[g]) begin
							c_next.tick_cnt = 5'(c_reg.tick_cnt + 5'h01);
							if (c_reg.tick_cnt == 5'(`BFS_OC_SKIP_TICKS - 1)) begin
								c_next.oc_st = bfs_pkg::BFS_OC_WATCH;
							end
						end
					end
					bfs_pkg::BFS_OC_WATCH: begin
						if (oc_set) begin
							c_next.oc_st = bfs_pkg::BFS_OC_LATCH;
						end else if (I_PWM_TICK[g]) begin
							if (c_reg.tick_cnt == 5'(`BFS_OC_TOTAL_TICKS - 1)) begin
								c_next.oc_st    = bfs_pkg::BFS_OC_IDLE;
								c_next.tick_cnt = 5'h00;
							end else begin
								c_next.tick_cnt = 5'(c_reg.tick_cnt + 5'h01);
							end
						end
					end
					bfs_pkg::BFS_OC_LATCH: begin
						c_next.tick_cnt = 5'h00;
					end
					default: begin
						c_next.oc_st    = bfs_pkg::BFS_OC_IDLE;
						c_next.tick_cnt = 5'h00;
					end
				endcase
				// A disabled channel restarts its sequencer, but a latch survives
				// until the shared clear.
				if (latch_clr || (!ch_alive && c_reg.oc_st != bfs_pkg::BFS_OC_LATCH)) begin
					c_next.oc_st    = bfs_pkg::BFS_OC_IDLE;
					c_next.tick_cnt = 5'h00;
				end
				// Fault latches; a set in the clearing cycle wins.
				c_next.fault_oc = oc_set | (c_reg.fault_oc & ~latch_clr);
				c_next.fault_uv = uv_set | (c_reg.fault_uv & ~latch_clr);
				// Power ok needs qualification, a steady window and no fault.
				c_next.pok = c_reg.run & c_reg.soft_done & win_filt[g]
					& ~c_next.fault_oc & ~c_next.fault_uv;
			end

			// Channel state register.
			always_ff @(posedge I_MCLK or negedge I_RST_N) begin
				if (!I_RST_N) begin
					c_reg <= '{oc_st: bfs_pkg::BFS_OC_IDLE, tick_cnt: 5'h00, default: 1'b0};
				end else begin
					c_reg <= c_next;
				end
			end

			assign ch_pok[g]   = c_reg.pok;
			assign ch_foc[g]   = c_reg.fault_oc;
			assign ch_fuv[g]   = c_reg.fault_uv;
			assign ch_soft[g]  = c_reg.soft_done;
			assign ch_run[g]   = c_reg.run;
			assign ch_ocact[g] = (c_reg.oc_st != bfs_pkg::BFS_OC_IDLE);
		end
	endgenerate

	// ************************************************************
	// Status word
	// ************************************************************
	// Gathers the live channel state for the read path.
	always_comb begin
		stat_word = 32'h00000000;
		stat_word[`BFS_ST_POK_LSB +: 2]   = ch_pok;
		stat_word[`BFS_ST_FOC_LSB +: 2]   = ch_foc;
		stat_word[`BFS_ST_FUV_LSB +: 2]   = ch_fuv;
		stat_word[`BFS_ST_SOFT_LSB +: 2]  = ch_soft;
		stat_word[`BFS_ST_RUN_LSB +: 2]   = ch_run;
		stat_word[`BFS_ST_OCACT_LSB +: 2] = ch_ocact;
		stat_word[`BFS_ST_RBIAS_BIT]      = t_reg.ramp_bias;
		stat_word[`BFS_ST_RDIV8_BIT]      = t_reg.ramp_div8;
	end

	// ************************************************************
	// Register port and ramp selection
	// ************************************************************
	// Read data stands for one cycle only; unmapped reads return zero.
	always_comb begin
		t_next = t_reg;
		t_next.rdata = 32'h00000000;
		if (I_WR && bfs_hit(I_ADDR, `BFS_ADDR_CFG)) begin
			t_next.cfg = I_WDATA & `BFS_CFG_RST;
		end
		if (I_RD) begin
			if (bfs_hit(I_ADDR, `BFS_ADDR_CFG)) begin
				t_next.rdata = t_reg.cfg;
			end else if (bfs_hit(I_ADDR, `BFS_ADDR_STAT)) begin
				t_next.rdata = stat_word;
			end
		end
		// A grounded sense pin moves the ramp source to the bias supply.
		t_next.ramp_bias = I_RAMP_SUPPLY_SENSE_GND;
		// Input over the level with the sense pin not grounded gives input/8, otherwise the fixed amplitude.
		t_next.ramp_div8 = ~I_RAMP_SUPPLY_SENSE_GND & I_RAMP_SUPPLY_SENSE_HIGH;
	end

	// Shared state register.
	always_ff @(posedge I_MCLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			t_reg <= '{cfg: `BFS_CFG_RST, rdata: 32'h00000000, default: 1'b0};
		end else begin
			t_reg <= t_next;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	// The pin is only ever pulled low; releasing it lets the pull-up show good.
	assign O_POWER_OK_OUTPUT      = 2'b00;
	assign O_POWER_OK_OUTPUT_OE_N = ch_pok;
	assign O_HIGH_SIDE_GATE       = hs_drv;
	assign O_LOW_SIDE_GATE        = ls_drv;
	assign O_SOFT_START_RUN       = ch_run;
	assign O_RAMP_FROM_BIAS       = t_reg.ramp_bias;
	assign O_RAMP_AMPLITUDE_DIV8  = t_reg.ramp_div8;
	assign O_RDATA                = t_reg.rdata;
endmodule

// file: src/bfs_cfg.svh
// Timing counts, register map and field positions of the buck fault supervisor.
`ifndef BFS_CFG_SVH
`define BFS_CFG_SVH
// ************************************************************
// ************************************************************

// ************************************************************
// Timing
// ************************************************************
`define BFS_MCLK_MHZ       40
`define BFS_HOLD_NS        400
`define BFS_HOLD_CYC       ((`BFS_HOLD_NS * `BFS_MCLK_MHZ + 999) / 1000)
`define BFS_FILT_NS        3000
`define BFS_FILT_CYC       ((`BFS_FILT_NS * `BFS_MCLK_MHZ + 999) / 1000)
`define BFS_OC_SKIP_TICKS  8
`define BFS_OC_TOTAL_TICKS 16

// ************************************************************
// Register map
// ************************************************************
`define BFS_ADDR_CFG       8'h00
`define BFS_ADDR_STAT      8'h04
`define BFS_CFG_RST        32'h00000003
`define BFS_CFG_UV_LSB     0
`define BFS_ST_POK_LSB     0
`define BFS_ST_FOC_LSB     2
`define BFS_ST_FUV_LSB     4
`define BFS_ST_SOFT_LSB    6
`define BFS_ST_RUN_LSB     8
`define BFS_ST_OCACT_LSB   10
`define BFS_ST_RBIAS_BIT   12
`define BFS_ST_RDIV8_BIT   13
`endif

// file: src/bfs_pkg.sv
// Types shared by the buck fault supervisor modules.
package bfs_pkg;
	// Overcurrent sequencer states, one-hot.
	typedef enum logic [3:0] {
		BFS_OC_IDLE  = 4'b0001,
		BFS_OC_SKIP  = 4'b0010,
		BFS_OC_WATCH = 4'b0100,
		BFS_OC_LATCH = 4'b1000
	} bfs_oc_e;

	// Per-channel supervisory state.
	typedef struct packed {
		bfs_oc_e    oc_st;
		logic [4:0] tick_cnt;
		logic       oc_held;
		logic       soft_done;
		logic       fault_oc;
		logic       fault_uv;
		logic       run;
		logic       pok;
	} bfs_ch_s;

	// Shared state of the top module.
	typedef struct packed {
		logic [31:0] cfg;
		logic [31:0] rdata;
		logic        ramp_bias;
		logic        ramp_div8;
	} bfs_top_s;

	// Gate drive results of one channel.
	typedef struct packed {
		logic hs;
		logic ls;
		logic sample;
	} bfs_gate_s;
endpackage

// file: src/bfs_filter.sv
// Stability filter for a comparator decision.
`timescale 1ns/1ps
`include "bfs_cfg.svh"
module bfs_filter #(
	parameter int unsigned CNT = `BFS_FILT_CYC
) (
	// Clock and reset.
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	// Raw and filtered decision.
	input  wire logic i_raw,
	output logic      o_filt
);
	localparam int unsigned W = $clog2(CNT + 1);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic         out;
	} bfs_filt_s;
	bfs_filt_s s_reg;
	bfs_filt_s s_next;

	// The output follows only after CNT consecutive differing samples.
	always_comb begin
		s_next = s_reg;
		if (i_raw == s_reg.out) begin
			s_next.cnt = '0;
		end else if (s_reg.cnt == W'(CNT - 1)) begin
			s_next.out = i_raw;
			s_next.cnt = '0;
		end else begin
			s_next.cnt = W'(s_reg.cnt + W'(1));
		end
	end

	// State register; a reset starts from "not in window".
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign o_filt = s_reg.out;
endmodule

// file: src/bfs_gate_seq.sv
// Gate sequencer of one channel: dead time and current sample timing.
`timescale 1ns/1ps
`include "bfs_cfg.svh"
module bfs_gate_seq #(
	parameter int unsigned HOLD = `BFS_HOLD_CYC
) (
	// Clock and reset.
	input  wire logic          i_clk,
	input  wire logic          i_rst_n,
	// Demand and permission.
	input  wire logic          i_allow,
	input  wire logic          i_want_hs,
	// Gate waveform monitors.
	input  wire logic          i_hs_fb,
	input  wire logic          i_ls_fb,
	// Drives and sample strobe.
	output bfs_pkg::bfs_gate_s o_gate
);
	localparam int unsigned W = $clog2(HOLD + 1);
	typedef struct packed {
		bfs_pkg::bfs_gate_s g;
		logic               hs_fb_d;
		logic               hrun;
		logic [W-1:0]       hcnt;
	} bfs_gseq_s;
	bfs_gseq_s s_reg;
	bfs_gseq_s s_next;

	// A switch turns on only when the other is seen off at its gate and not driven.
	always_comb begin
		s_next = s_reg;
		s_next.hs_fb_d = i_hs_fb;
		s_next.g.sample = 1'b0;
		s_next.g.hs = i_allow & i_want_hs & ~i_ls_fb & ~s_reg.g.ls;
		s_next.g.ls = i_allow & ~i_want_hs & ~i_hs_fb & ~s_reg.g.hs;
		// Sample is timed from the observed high-side turn-off, not the command.
		if (i_hs_fb) begin
			s_next.hrun = 1'b0;
			s_next.hcnt = '0;
		end else if (s_reg.hs_fb_d) begin
			s_next.hrun = 1'b1;
			s_next.hcnt = '0;
		end else if (s_reg.hrun) begin
			if (s_reg.hcnt == W'(HOLD - 1)) begin
				s_next.hrun = 1'b0;
				s_next.g.sample = 1'b1;
			end else begin
				s_next.hcnt = W'(s_reg.hcnt + W'(1));
			end
		end
	end

	// State register; both gates off in reset.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign o_gate = s_reg.g;
endmodule

// file: tb/bfs_checker_properties.sv
// Port-level assertions of the buck fault supervisor and their bind.
`timescale 1ns/1ps
module bfs_checker (
	// Clock, reset and inputs.
	input wire logic        I_MCLK,
	input wire logic        I_RST_N,
	input wire logic        I_POR_OK,
	input wire logic        I_RD,
	input wire logic        I_RAMP_SUPPLY_SENSE_GND,
	input wire logic        I_RAMP_SUPPLY_SENSE_HIGH,
	input wire logic [1:0]  I_CHANNEL_ENABLE,
	input wire logic [1:0]  I_SOFT_QUAL,
	input wire logic [1:0]  I_HIGH_SIDE_GATE_MON,
	input wire logic [1:0]  I_LOW_SIDE_GATE_MON,
	// Outputs under watch.
	input wire logic [31:0] O_RDATA,
	input wire logic [1:0]  O_HIGH_SIDE_GATE,
	input wire logic [1:0]  O_LOW_SIDE_GATE,
	input wire logic [1:0]  O_POWER_OK_OUTPUT,
	input wire logic [1:0]  O_POWER_OK_OUTPUT_OE_N,
	input wire logic [1:0]  O_SOFT_START_RUN,
	input wire logic        O_RAMP_FROM_BIAS,
	input wire logic        O_RAMP_AMPLITUDE_DIV8
);
	logic [1:0] seen_reg;
	default clocking @(posedge I_MCLK); endclocking
	default disable iff (!I_RST_N);
	// Qualification seen since reset; it never clears, so the check below is one-sided.
	always_ff @(posedge I_MCLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			seen_reg <= 2'h0;
		end else begin
			seen_reg <= seen_reg | I_SOFT_QUAL;
		end
	end
	// Gate, power ok, ramp and read data relations.
	a_hs_dead_time: assert property ((O_HIGH_SIDE_GATE & $past(I_LOW_SIDE_GATE_MON)) == 2'h0)
		else $error("high side driven while low side seen on");
	a_ls_dead_time: assert property ((O_LOW_SIDE_GATE & $past(I_HIGH_SIDE_GATE_MON)) == 2'h0)
		else $error("low side driven while high side seen on");
	a_pok_open_drain: assert property (O_POWER_OK_OUTPUT == 2'h0)
		else $error("power ok data not held low");
	a_pok_after_soft: assert property ((O_POWER_OK_OUTPUT_OE_N & ~seen_reg) == 2'h0)
		else $error("power ok released before qualification");
	a_gates_need_run: assert property (((O_HIGH_SIDE_GATE | O_LOW_SIDE_GATE) & ~$past(O_SOFT_START_RUN)) == 2'h0)
		else $error("gate driven on a stopped channel");
	a_fault_stays_off: assert property ($fell(O_SOFT_START_RUN[0]) && $past(I_CHANNEL_ENABLE[0]) && $past(I_POR_OK)
		|-> !O_POWER_OK_OUTPUT_OE_N[0] ##1 !O_SOFT_START_RUN[0])
		else $error("fault stop without power ok low or latch");
	a_ramp_bias_src: assert property ($past(I_RST_N) |-> O_RAMP_FROM_BIAS == $past(I_RAMP_SUPPLY_SENSE_GND))
		else $error("ramp source wrong");
	a_ramp_div_sel: assert property ($past(I_RST_N)
		|-> O_RAMP_AMPLITUDE_DIV8 == ($past(I_RAMP_SUPPLY_SENSE_HIGH) && !$past(I_RAMP_SUPPLY_SENSE_GND)))
		else $error("ramp amplitude choice wrong");
	a_rdata_idle: assert property (!$past(I_RD) |-> O_RDATA == 32'h0)
		else $error("read data outside its cycle");
	c_fault_off: cover property ($fell(O_SOFT_START_RUN[0]));
	c_pok_up: cover property ($rose(O_POWER_OK_OUTPUT_OE_N[0]));
	c_div8_on: cover property ($rose(O_RAMP_AMPLITUDE_DIV8));
endmodule
bind bfs_supervisor bfs_checker u_bfs_checker (.I_MCLK, .I_RST_N, .I_POR_OK, .I_RD, .I_RAMP_SUPPLY_SENSE_GND,
	.I_RAMP_SUPPLY_SENSE_HIGH, .I_CHANNEL_ENABLE, .I_SOFT_QUAL, .I_HIGH_SIDE_GATE_MON, .I_LOW_SIDE_GATE_MON,
	.O_RDATA, .O_HIGH_SIDE_GATE, .O_LOW_SIDE_GATE, .O_POWER_OK_OUTPUT, .O_POWER_OK_OUTPUT_OE_N,
	.O_SOFT_START_RUN, .O_RAMP_FROM_BIAS, .O_RAMP_AMPLITUDE_DIV8);

// file: tb/bfs_fet_model.sv
// Behavioural switch pair whose gate monitors trail the drives.
`timescale 1ns/1ps
module bfs_fet_model (
	// Clock and reset.
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	// Slow parts lag one more cycle.
	input  wire logic       i_slow,
	// Drives in, observed gate levels out.
	input  wire logic [1:0] i_hs,
	input  wire logic [1:0] i_ls,
	output logic      [1:0] o_hs_mon,
	output logic      [1:0] o_ls_mon
);
	logic [3:0] lag1_reg;
	logic [3:0] lag2_reg;
	// Gates charge slowly, so the dead time must stretch with the part.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			lag1_reg <= 4'h0;
			lag2_reg <= 4'h0;
		end else begin
			lag1_reg <= {i_hs, i_ls};
			lag2_reg <= lag1_reg;
		end
	end
	// Monitors show the real gate, never the drive.
	assign {o_hs_mon, o_ls_mon} = i_slow ? lag2_reg : lag1_reg;
endmodule

// file: tb/tb.sv
// Self-checking bench of the buck fault supervisor.
`timescale 1ns/1ps
module tb;
	logic        clk = 1'b0, rst_n = 1'b0, por = 1'b1, slow = 1'b0, gnd = 1'b0, hi = 1'b0;
	logic        wr = 1'b0, rd = 1'b0, rd_q = 1'b0, ramp_bias, div8;
	logic [1:0]  en = 2'h3, tick = 2'h0, dem = 2'h0, ovr = 2'h0, uv = 2'h0, win = 2'h3, qual = 2'h0;
	logic [1:0]  hs, ls, hsm, lsm, pok, oe_n, run;
	logic [7:0]  addr = 8'h0;
	logic [31:0] wdata = 32'h0, rdata, pins;
	logic [63:0] exp_q[$];
	int          bad_count = 0, cmp_count = 0, hs_rise = 0, ph = 0, h;

	bfs_supervisor #(.FILT_CYC(4), .HOLD_CYC(3)) u_bfs_supervisor (.I_MCLK(clk), .I_RST_N(rst_n), .I_POR_OK(por),
		.I_CHANNEL_ENABLE(en), .I_PWM_TICK(tick), .I_PWM_DEMAND(dem), .I_CURRENT_SENSE_OVER(ovr),
		.I_FEEDBACK_SENSE_UNDER(uv), .I_FEEDBACK_SENSE_IN_WIN(win), .I_SOFT_QUAL(qual),
		.I_HIGH_SIDE_GATE_MON(hsm), .I_LOW_SIDE_GATE_MON(lsm), .I_RAMP_SUPPLY_SENSE_GND(gnd),
		.I_RAMP_SUPPLY_SENSE_HIGH(hi), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
		.O_HIGH_SIDE_GATE(hs), .O_LOW_SIDE_GATE(ls), .O_POWER_OK_OUTPUT(pok), .O_POWER_OK_OUTPUT_OE_N(oe_n),
		.O_SOFT_START_RUN(run), .O_RAMP_FROM_BIAS(ramp_bias), .O_RAMP_AMPLITUDE_DIV8(div8));
	bfs_fet_model u_bfs_fet_model (.i_clk(clk), .i_rst_n(rst_n), .i_slow(slow), .i_hs(hs), .i_ls(ls),
		.o_hs_mon(hsm), .o_ls_mon(lsm));

	// Clock at 40 MHz.
	always #12.5 clk = ~clk;
	// Eight clocks per switching cycle; channel two asks at random to stress dead time.
	// Channel one asks for four clocks, since with the slow pair a shorter demand is eaten whole by the dead time.
	always @(posedge clk) begin
		ph <= (ph + 1) % 8;
		tick <= {ph == 3, ph == 7};
		dem <= {1'($urandom), ph < 4};
	end
	// High-side pulses of channel one are counted.
	always @(posedge hs[0]) hs_rise++;
	// Read data stand only in the cycle after the strobe; the oldest note is due.
	always @(posedge clk) begin
		rd_q <= rd;
		// Pin levels are taken a cycle late, so they are never read at the edge that moves them.
		pins <= {26'h0, oe_n, run, ramp_bias, div8};
		if (rd_q)
			chk(rdata, exp_q.pop_front());
	end

	task automatic chk(input logic [31:0] got, input logic [63:0] note);
		cmp_count++;
		if ((got & note[63:32]) !== note[31:0]) begin
			bad_count++;
			$display("[ERR] %0t got %h want %h", $time, got & note[63:32], note[31:0]);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	// One access, then an idle cycle so a strobe is never set twice in one step.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= !w;
		if (!w)
			exp_q.push_back({m, d});
		cyc(1);
		wr <= 1'b0;
		rd <= 1'b0;
		cyc(1);
	endtask
	task automatic st(input logic [31:0] e, input logic [31:0] m);
		bus(1'b0, 8'h04, e, m);
	endtask
	task automatic final_report;
		if (bad_count == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Main sequence.
	initial begin
		logic [1:0] v;
		void'($urandom(32'h31d9));
		cyc(4);
		rst_n <= 1'b1;
		cyc(2);
		bus(1'b0, 8'h00, 32'h3, 32'hffffffff);
		bus(1'b1, 8'h00, 32'hffffffff, 32'h0);
		bus(1'b0, 8'h00, 32'h3, 32'hffffffff);
		bus(1'b1, 8'h04, 32'hffffffff, 32'h0);
		bus(1'b1, 8'h08, 32'h5a5a, 32'h0);
		bus(1'b0, 8'h08, 32'h0, 32'hffffffff);
		st(32'h300, 32'h3fff);
		chk(pins, {32'h30, 32'h0});
		for (int i = 0; i < 8; i++) begin
			v = i < 4 ? 2'(i) : 2'($urandom);
			{gnd, hi} <= v;
			cyc(2);
			st({18'h0, v[0] & !v[1], v[1], 12'h0}, 32'h3000);
			chk(pins, {32'h3, 30'h0, v[1], v[0] & !v[1]});
		end
		// Qualified start, a short window excursion, then a long one.
		qual <= 2'h3;
		cyc(8);
		st(32'h3c3, 32'hfff);
		chk(pins, {32'h3c, 32'h3c});
		win[0] <= 1'b0;
		cyc(1 + $urandom % 3);
		win[0] <= 1'b1;
		cyc(2);
		st(32'h3c3, 32'hfff);
		win[0] <= 1'b0;
		cyc(8);
		st(32'h3c2, 32'hfff);
		chk(pins, {32'h30, 32'h20});
		win[0] <= 1'b1;
		// Overcurrent that clears inside the skipping interval, with a slow switch pair.
		slow <= 1'b1;
		ovr[0] <= 1'b1;
		cyc(16);
		h = hs_rise;
		cyc(16);
		chk(32'(hs_rise - h), {32'hffffffff, 32'h0});
		st(32'h700, 32'hf0c);
		ovr[0] <= 1'b0;
		h = hs_rise;
		cyc(24);
		chk(32'(hs_rise > h), {32'hffffffff, 32'h1});
		cyc(100);
		st(32'h300, 32'hf0c);
		// A second trip inside the watch interval latches channel one only.
		slow <= 1'b0;
		ovr[0] <= 1'b1;
		cyc(16);
		ovr[0] <= 1'b0;
		cyc(64);
		ovr[0] <= 1'b1;
		cyc(24);
		ovr[0] <= 1'b0;
		st(32'h206, 32'h30f);
		chk(pins, {32'h3c, 32'h28});
		h = hs_rise;
		cyc(16);
		chk(32'(hs_rise - h), {32'hffffffff, 32'h0});
		qual <= 2'h0;
		en <= 2'h2;
		cyc(4);
		st(32'h4, 32'h4);
		en <= 2'h0;
		cyc(4);
		en <= 2'h3;
		cyc(4);
		st(32'h300, 32'h30c);
		// Undervoltage is ignored before qualification and latches after it.
		uv[0] <= 1'b1;
		cyc(6);
		st(32'h300, 32'h330);
		uv[0] <= 1'b0;
		qual <= 2'h3;
		cyc(4);
		uv[0] <= 1'b1;
		cyc(1);
		uv[0] <= 1'b0;
		cyc(3);
		st(32'h210, 32'h330);
		por <= 1'b0;
		cyc(3);
		por <= 1'b1;
		cyc(4);
		st(32'h300, 32'h330);
		bus(1'b1, 8'h00, 32'h2, 32'h0);
		uv[0] <= 1'b1;
		cyc(4);
		uv[0] <= 1'b0;
		st(32'h300, 32'h330);
		cyc(2);
		final_report();
	end
	// Hang guard: the sequence needs about four hundred clocks.
	initial begin
		cyc(5000);
		bad_count++;
		final_report();
	end
endmodule
